// ===== verilog/pspp_pkg.sv
/*
  Shared constants of the serial programming port: command codes, transfer
  sizes, user operation codes and the timing counts of the programmer end.
  Assumes a 50 MHz system clock on the programmer end.
*/
package pspp_pkg;
    // command codes, first byte of every operation
    localparam logic [7:0] CMD_READ = 8'h15;
    localparam logic [7:0] CMD_PROG = 8'h25;
    localparam logic [7:0] CMD_VERIFY = 8'h35;

    // transfer sizes
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
    localparam logic [4:0] OUT_BITS = 5'h10;
    localparam logic [2:0] TX_BYTES_READ = 3'h3;
    localparam logic [2:0] TX_BYTES_PROG = 3'h5;
    localparam logic [2:0] RX_BYTES = 3'h2;

    // user operation codes of the programmer end
    localparam logic [1:0] OP_READ = 2'h0;
    localparam logic [1:0] OP_PROG = 2'h1;
    localparam logic [1:0] OP_VERIFY = 2'h2;

    // memory size
    localparam int MEM_DEPTH = 2048;

    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // timing, figures in ns, counts in system clocks
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCLK_PERIOD_NS = 1000;
    localparam int TRANSFER_SPACING_NS = 2000;
    localparam int WAIT_AFTER_NS = 2000;
    localparam int READ_PULSE_NS = 500;
    localparam int PROG_PULSE_NS = 190000;
    localparam int ENTRY_SETTLE_NS = 2000;
    localparam int FINAL_BIT_RELEASE_HOLD_NS = 100;

    localparam int SCLK_HALF_CYC = (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SPACING_CYC = (TRANSFER_SPACING_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_CYC = (WAIT_AFTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_PULSE_CYC = (READ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROG_PULSE_CYC = (PROG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ENTRY_CYC = (ENTRY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ===== verilog/pspp_if.sv
/*
  Link between the programmer and the device: serial clock, strobe,
  programming-voltage level and the shared data wire.
  Assumes each end drives only its own enable; nobody driving reads high.
*/
`timescale 1ns/1ps
interface pspp_if;
    logic sclk;
    logic program_strobe_n;
    logic vpp_on;
    logic dev_sda_out;
    logic dev_sda_oe;
    logic prg_sda_out;
    logic prg_sda_oe;
    logic sda;

    // wire level from the enables, pulled high when released
    assign sda = dev_sda_oe ? dev_sda_out : (prg_sda_oe ? prg_sda_out : 1'b1);

    modport dev (
        input sclk, program_strobe_n, vpp_on, sda,
        output dev_sda_out, dev_sda_oe
    );
    modport prg (
        output sclk, program_strobe_n, vpp_on, prg_sda_out, prg_sda_oe,
        input sda
    );
endinterface

// ===== verilog/pspp_device.sv
/*
  Device end of the serial programming port: byte shifter on the serial
  clock, command sequencer and program memory on the system clock.
  Assumes the programmer keeps its spacing times, so the read word and the
  arm toggle stand still for microseconds before the first output edge.
*/
// Notes on behaviour
// RULE_01: programmer raises lines, then programming voltage
// RULE_02: all bits travel least significant first
// RULE_03: device samples incoming bits on rising clock
// RULE_04: device changes outgoing bits on falling clock
// RULE_05: transfers are whole bytes of eight clocks
// RULE_06: first byte is command, steering later bytes
// RULE_07: read: command, address bytes, strobe fetches word
// RULE_08: after strobe release, shift word low byte first
// RULE_09: data pin drives from first falling edge
// RULE_10: data pin released after sixteenth rising edge
// RULE_11: program: command, address, data, strobe writes word
// RULE_12: verify command programs exactly like program
// RULE_13: second verify strobe reads word back into latch
// RULE_14: verify word shifted out, low byte first
// RULE_15: programmer waits 2 us before read strobe
// RULE_16: programmer waits 2 us after read strobe
// RULE_17: programmer waits 2 us before program strobe
// RULE_18: extra programming pulse lasts 0.19 to 5.25 ms; the programmer issues no extra pulse
// RULE_19: serial clock period at least 1 us
// RULE_20: programmer spaces bytes at least 2 us
// RULE_21: unknown command bytes are ignored, memory untouched
`timescale 1ns/1ps
module pspp_device #(
    parameter int DEPTH = pspp_pkg::MEM_DEPTH
) (
    // system side
    input wire logic clk,
    input wire logic reset_n,
    // link side
    pspp_if.dev link,
    // user side status
    output logic prog_mode,
    output logic write_pulse
);
    localparam int AW = $clog2(DEPTH);

    typedef enum logic [9:0] {
        ST_CMD = 10'h001,
        ST_ADL = 10'h002,
        ST_ADH = 10'h004,
        ST_DTL = 10'h008,
        ST_DTH = 10'h010,
        ST_RDW = 10'h020,
        ST_PGW = 10'h040,
        ST_PGR = 10'h080,
        ST_VFW = 10'h100,
        ST_RLS = 10'h200
    } pspp_dev_st_e;

    // rising-edge state of the serial clock domain
    typedef struct packed {
        logic [7:0] sh;
        logic [2:0] bit_cnt;
        logic [7:0] rx_byte;
        logic byte_tgl;
        logic [4:0] out_cnt;
    } pspp_rise_s;

    // falling-edge state of the serial clock domain
    typedef struct packed {
        logic drive;
        logic sda_out;
        logic [14:0] sh;
        logic arm_seen;
    } pspp_fall_s;

    // system clock state
    typedef struct packed {
        logic [2:0] tgl_s;
        logic [2:0] stb_s;
        logic [2:0] vpp_s;
        logic stb_lvl;
        logic vpp_lvl;
        pspp_dev_st_e st;
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [15:0] data;
        logic [15:0] word;
        logic arm_tgl;
        logic wr;
    } pspp_sys_s;

    pspp_rise_s p_r;
    pspp_rise_s p_nxt;
    pspp_fall_s n_r;
    pspp_fall_s n_nxt;
    pspp_sys_s c_r;
    pspp_sys_s c_nxt;
    logic [15:0] mem [DEPTH];
    logic [15:0] mem_q;
    logic byte_ev;
    logic stb_fall;
    logic stb_rise;

    // input shifter; ignored while the device owns the wire
    always_comb begin
        p_nxt = p_r;
        if (n_r.drive) begin
            if (p_r.out_cnt != pspp_pkg::OUT_BITS) begin
                p_nxt.out_cnt = p_r.out_cnt + 5'h01; // counts output bits to release
            end
        end else begin
            p_nxt.out_cnt = 5'h00;
            p_nxt.sh = {link.sda, p_r.sh[7:1]}; // [RULE_02] [RULE_03]
            p_nxt.bit_cnt = p_r.bit_cnt + 3'h1;
            if (p_r.bit_cnt == pspp_pkg::BYTE_LAST_BIT) begin
                p_nxt.rx_byte = {link.sda, p_r.sh[7:1]}; // [RULE_05]
                p_nxt.byte_tgl = ~p_r.byte_tgl;
            end
        end
    end

    always_ff @(posedge link.sclk or negedge reset_n) begin
        if (!reset_n) begin
            p_r <= '0;
        end else begin
            p_r <= p_nxt;
        end
    end

    // output shifter; word and arm are quasi-static, settled long before the edge
    always_comb begin
        n_nxt = n_r;
        if (c_r.arm_tgl != n_r.arm_seen) begin
            n_nxt.arm_seen = c_r.arm_tgl;
            n_nxt.drive = 1'b1; // [RULE_09]
            n_nxt.sda_out = c_r.word[0]; // [RULE_02] [RULE_04]
            n_nxt.sh = c_r.word[15:1];
        end else if (n_r.drive) begin
            if (p_r.out_cnt == pspp_pkg::OUT_BITS) begin
                n_nxt.drive = 1'b0;
            end else begin
                n_nxt.sda_out = n_r.sh[0]; // [RULE_04] [RULE_08]
                n_nxt.sh = {1'b0, n_r.sh[14:1]};
            end
        end
    end

    always_ff @(negedge link.sclk or negedge reset_n) begin
        if (!reset_n) begin
            n_r <= '0;
        end else begin
            n_r <= n_nxt;
        end
    end

    // pin drive; enable drops at the sixteenth rising edge itself
    assign link.dev_sda_oe = n_r.drive & (p_r.out_cnt != pspp_pkg::OUT_BITS); // [RULE_10]
    assign link.dev_sda_out = n_r.sda_out;

    // program memory read port
    assign mem_q = mem[c_r.addr[AW-1:0]];

    // edges of the synchronised link signals, second and third stage only
    assign byte_ev = c_r.tgl_s[1] ^ c_r.tgl_s[2];
    assign stb_fall = c_r.stb_lvl & ~c_r.stb_s[1] & ~c_r.stb_s[2];
    assign stb_rise = ~c_r.stb_lvl & c_r.stb_s[1] & c_r.stb_s[2];

    // command sequencer
    always_comb begin
        c_nxt = c_r;
        c_nxt.wr = 1'b0;
        c_nxt.tgl_s = {c_r.tgl_s[1:0], p_r.byte_tgl};
        c_nxt.stb_s = {c_r.stb_s[1:0], link.program_strobe_n};
        c_nxt.vpp_s = {c_r.vpp_s[1:0], link.vpp_on};
        if (c_r.stb_s[1] == c_r.stb_s[2]) begin
            c_nxt.stb_lvl = c_r.stb_s[2];
        end
        if (c_r.vpp_s[1] == c_r.vpp_s[2]) begin
            c_nxt.vpp_lvl = c_r.vpp_s[2];
        end
        case (c_r.st)
            ST_CMD: begin
                if (byte_ev) begin
                    case (p_r.rx_byte)
                        pspp_pkg::CMD_READ, pspp_pkg::CMD_PROG, pspp_pkg::CMD_VERIFY: begin
                            c_nxt.cmd = p_r.rx_byte; // [RULE_06]
                            c_nxt.st = ST_ADL;
                        end
                        default: begin
                            c_nxt.st = ST_CMD; // [RULE_21]
                        end
                    endcase
                end
            end
            ST_ADL: begin
                if (byte_ev) begin
                    c_nxt.addr[7:0] = p_r.rx_byte;
                    c_nxt.st = ST_ADH;
                end
            end
            ST_ADH: begin
                if (byte_ev) begin
                    c_nxt.addr[15:8] = p_r.rx_byte;
                    // read takes no data bytes
                    c_nxt.st = (c_r.cmd == pspp_pkg::CMD_READ) ? ST_RDW : ST_DTL; // [RULE_06]
                end
            end
            ST_DTL: begin
                if (byte_ev) begin
                    c_nxt.data[7:0] = p_r.rx_byte;
                    c_nxt.st = ST_DTH;
                end
            end
            ST_DTH: begin
                if (byte_ev) begin
                    c_nxt.data[15:8] = p_r.rx_byte;
                    c_nxt.st = ST_PGW;
                end
            end
            ST_RDW: begin
                if (stb_fall) begin
                    c_nxt.word = mem_q; // [RULE_07]
                    c_nxt.st = ST_RLS;
                end
            end
            ST_PGW: begin
                if (stb_fall) begin
                    c_nxt.wr = 1'b1; // [RULE_11] [RULE_12]
                    c_nxt.st = ST_PGR;
                end
            end
            ST_PGR: begin
                if (stb_rise) begin
                    c_nxt.st = (c_r.cmd == pspp_pkg::CMD_VERIFY) ? ST_VFW : ST_CMD;
                end
            end
            ST_VFW: begin
                if (stb_fall) begin
                    c_nxt.word = mem_q; // [RULE_13]
                    c_nxt.st = ST_RLS;
                end
            end
            ST_RLS: begin
                if (stb_rise) begin
                    c_nxt.arm_tgl = ~c_r.arm_tgl; // [RULE_08] [RULE_14]
                    c_nxt.st = ST_CMD;
                end
            end
            default: begin
                c_nxt.st = ST_CMD;
            end
        endcase
        // outside programming mode the sequencer waits for a command
        if (!c_r.vpp_lvl) begin
            c_nxt.st = ST_CMD;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            c_r <= '{tgl_s: 3'h0, stb_s: 3'h7, vpp_s: 3'h0, stb_lvl: 1'b1,
                     vpp_lvl: 1'b0, st: ST_CMD, cmd: pspp_pkg::BYTE_RST,
                     addr: pspp_pkg::WORD_RST, data: pspp_pkg::WORD_RST,
                     word: pspp_pkg::WORD_RST, arm_tgl: 1'b0, wr: 1'b0};
        end else begin
            c_r <= c_nxt;
        end
    end

    // memory write, one cycle after the strobe edge; address and data stand
    always_ff @(posedge clk) begin
        if (c_r.wr) begin
            mem[c_r.addr[AW-1:0]] <= c_r.data; // [RULE_11] [RULE_12]
        end
    end

    assign prog_mode = c_r.vpp_lvl;
    assign write_pulse = c_r.wr;
endmodule

// ===== verilog/pspp_programmer.sv
/*
  Programmer end of the serial programming port: makes the serial clock by
  division, sends command, address and data bytes, strobes and reads back.
  Assumes a 50 MHz clock; one request at a time on the user side.
*/
`timescale 1ns/1ps
module pspp_programmer #(
    parameter int PROG_PULSE_CYC = pspp_pkg::PROG_PULSE_CYC
) (
    // system
    input wire logic clk,
    input wire logic reset_n,
    // link
    pspp_if.prg link,
    // request
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [1:0] req_op,
    input wire logic [15:0] req_addr,
    input wire logic [15:0] req_data,
    // answer
    output logic rsp_valid,
    output logic [15:0] rsp_data
);
    typedef enum logic [6:0] {
        ST_ENTRY = 7'h01,
        ST_IDLE = 7'h02,
        ST_BLO = 7'h04,
        ST_BHI = 7'h08,
        ST_GAP = 7'h10,
        ST_STB = 7'h20,
        ST_SWT = 7'h40
    } pspp_prg_st_e;

    typedef struct packed {
        pspp_prg_st_e st;
        logic vpp;
        logic sclk;
        logic stb_n;
        logic sda_o;
        logic sda_oe;
        logic [2:0] sda_s;
        logic sda_lvl;
        logic [15:0] cnt;
        logic [2:0] bit_cnt;
        logic [2:0] left;
        logic [31:0] pend;
        logic [7:0] sh;
        logic rx;
        logic second;
        logic [1:0] op;
        logic [15:0] rxw;
        logic rsp_v;
        logic [15:0] rsp_d;
    } pspp_prg_s;

    pspp_prg_s r;
    pspp_prg_s r_nxt;

    // sequencer
    always_comb begin
        r_nxt = r;
        r_nxt.rsp_v = 1'b0;
        r_nxt.cnt = r.cnt + 16'h0001;
        r_nxt.sda_s = {r.sda_s[1:0], link.sda};
        if (r.sda_s[1] == r.sda_s[2]) begin
            r_nxt.sda_lvl = r.sda_s[2];
        end
        case (r.st)
            ST_ENTRY: begin
                // all lines already high; now the programming voltage
                if (r.cnt == 16'(pspp_pkg::ENTRY_CYC - 1)) begin
                    r_nxt.vpp = 1'b1; // [RULE_01]
                    r_nxt.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (req_valid) begin
                    r_nxt.op = req_op;
                    r_nxt.second = 1'b0;
                    r_nxt.rx = 1'b0;
                    r_nxt.left = (req_op == pspp_pkg::OP_READ) ? pspp_pkg::TX_BYTES_READ
                                                                : pspp_pkg::TX_BYTES_PROG;
                    case (req_op)
                        pspp_pkg::OP_PROG: r_nxt.sh = pspp_pkg::CMD_PROG; // [RULE_11]
                        pspp_pkg::OP_VERIFY: r_nxt.sh = pspp_pkg::CMD_VERIFY; // [RULE_12]
                        default: r_nxt.sh = pspp_pkg::CMD_READ; // [RULE_07]
                    endcase
                    r_nxt.pend = {req_data, req_addr};
                    r_nxt.sclk = 1'b0;
                    r_nxt.sda_o = r_nxt.sh[0]; // [RULE_02]
                    r_nxt.bit_cnt = 3'h0;
                    r_nxt.cnt = 16'h0000;
                    r_nxt.st = ST_BLO;
                end
            end
            ST_BLO: begin
                if (r.cnt == 16'(pspp_pkg::SCLK_HALF_CYC - 1)) begin
                    r_nxt.sclk = 1'b1; // [RULE_19]
                    r_nxt.rxw = r.rx ? {r.sda_lvl, r.rxw[15:1]} : r.rxw; // [RULE_02]
                    r_nxt.cnt = 16'h0000;
                    r_nxt.st = ST_BHI;
                end
            end
            ST_BHI: begin
                if (r.cnt == 16'(pspp_pkg::SCLK_HALF_CYC - 1)) begin
                    r_nxt.cnt = 16'h0000;
                    if (r.bit_cnt == pspp_pkg::BYTE_LAST_BIT) begin
                        r_nxt.left = r.left - 3'h1; // [RULE_05]
                        r_nxt.st = ST_GAP;
                    end else begin
                        r_nxt.bit_cnt = r.bit_cnt + 3'h1;
                        r_nxt.sclk = 1'b0;
                        r_nxt.sh = {1'b0, r.sh[7:1]};
                        r_nxt.sda_o = r.sh[1];
                        r_nxt.st = ST_BLO;
                    end
                end
            end
            ST_GAP: begin
                // spacing between bytes, also the wait before a strobe
                if (r.cnt == 16'(pspp_pkg::SPACING_CYC - 1)) begin // [RULE_15] [RULE_17] [RULE_20]
                    r_nxt.cnt = 16'h0000;
                    r_nxt.bit_cnt = 3'h0;
                    if (r.left != 3'h0) begin
                        r_nxt.sh = r.pend[7:0];
                        r_nxt.sda_o = r.pend[0];
                        r_nxt.pend = {8'h00, r.pend[31:8]};
                        r_nxt.sclk = 1'b0;
                        r_nxt.st = ST_BLO;
                    end else if (r.rx) begin
                        r_nxt.rsp_v = 1'b1; // [RULE_08] [RULE_14]
                        r_nxt.rsp_d = r.rxw;
                        r_nxt.sda_oe = 1'b1;
                        r_nxt.sda_o = 1'b1;
                        r_nxt.st = ST_IDLE;
                    end else begin
                        r_nxt.stb_n = 1'b0;
                        r_nxt.st = ST_STB;
                    end
                end
            end
            ST_STB: begin
                if ((r.op == pspp_pkg::OP_READ || r.second)
                        ? (r.cnt == 16'(pspp_pkg::READ_PULSE_CYC - 1))
                        : (r.cnt == 16'(PROG_PULSE_CYC - 1))) begin
                    r_nxt.stb_n = 1'b1; // single pulse, no added pulses issued [RULE_18]
                    r_nxt.cnt = 16'h0000;
                    r_nxt.st = ST_SWT;
                end
            end
            ST_SWT: begin
                if (r.cnt == 16'(pspp_pkg::WAIT_CYC - 1)) begin // [RULE_16]
                    r_nxt.cnt = 16'h0000;
                    if (r.op == pspp_pkg::OP_PROG) begin
                        r_nxt.rsp_v = 1'b1;
                        r_nxt.rsp_d = pspp_pkg::WORD_RST;
                        r_nxt.st = ST_IDLE;
                    end else if (r.op == pspp_pkg::OP_VERIFY && !r.second) begin
                        r_nxt.second = 1'b1; // [RULE_13]
                        r_nxt.stb_n = 1'b0;
                        r_nxt.st = ST_STB;
                    end else begin
                        // release the wire in the same cycle as the device's first falling edge
                        r_nxt.sda_oe = 1'b0;
                        r_nxt.rx = 1'b1;
                        r_nxt.left = pspp_pkg::RX_BYTES;
                        r_nxt.bit_cnt = 3'h0;
                        r_nxt.sclk = 1'b0;
                        r_nxt.st = ST_BLO;
                    end
                end
            end
            default: begin
                r_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '{st: ST_ENTRY, vpp: 1'b0, sclk: 1'b1, stb_n: 1'b1, sda_o: 1'b1,
                   sda_oe: 1'b1, sda_s: 3'h7, sda_lvl: 1'b1, cnt: 16'h0000,
                   bit_cnt: 3'h0, left: 3'h0, pend: 32'h00000000,
                   sh: pspp_pkg::BYTE_RST, rx: 1'b0, second: 1'b0, op: 2'h0,
                   rxw: pspp_pkg::WORD_RST, rsp_v: 1'b0, rsp_d: pspp_pkg::WORD_RST};
        end else begin
            r <= r_nxt;
        end
    end

    // the command byte goes first; its bit 0 is driven at the first fall
    assign link.sclk = r.sclk;
    assign link.program_strobe_n = r.stb_n;
    assign link.vpp_on = r.vpp;
    assign link.prg_sda_out = r.sda_o;
    assign link.prg_sda_oe = r.sda_oe;
    assign req_ready = (r.st == ST_IDLE);
    assign rsp_valid = r.rsp_v;
    assign rsp_data = r.rsp_d;
endmodule

// ===== bench/pspp_monitor.sv
/*
  Checker on the link wires of the serial programming port.
  Assumes sclk is divided from clk, so clk sees every sclk edge.
*/
`timescale 1ns/1ps
module pspp_monitor (
    // system
    input wire logic clk,
    input wire logic reset_n,
    // link
    input wire logic sclk,
    input wire logic program_strobe_n,
    input wire logic vpp_on,
    input wire logic dev_sda_out,
    input wire logic dev_sda_oe,
    input wire logic prg_sda_out,
    input wire logic prg_sda_oe,
    input wire logic sda
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic [4:0] rise_cnt_r;

    // rises seen while the device drives; cleared once it lets go
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rise_cnt_r <= 5'h00;
        end else if (!dev_sda_oe) begin
            rise_cnt_r <= 5'h00;
        end else if ($rose(sclk)) begin
            rise_cnt_r <= rise_cnt_r + 5'h01;
        end
    end

    property p_one_driver; !(dev_sda_oe && prg_sda_oe); endproperty
    a_one_driver: assert property (p_one_driver)
        else $error("both ends drive sda");
    property p_out_on_fall; $changed(dev_sda_out) |-> $fell(sclk); endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("device data moved off a falling sclk");
    property p_oe_on_fall; $rose(dev_sda_oe) |-> $fell(sclk) && program_strobe_n; endproperty
    a_oe_on_fall: assert property (p_oe_on_fall)
        else $error("device drive began off a falling sclk");
    property p_oe_off_rise; $fell(dev_sda_oe) |-> $rose(sclk) && rise_cnt_r == 5'h0F; endproperty
    a_oe_off_rise: assert property (p_oe_off_rise)
        else $error("device drive not released at the sixteenth rise");
    // the sixteenth rise lets go of the wire; the device samples nothing at that rise
    property p_in_stable; $rose(sclk) && !$past(dev_sda_oe) |-> $stable(sda); endproperty
    a_in_stable: assert property (p_in_stable)
        else $error("sda moved at a sampling rise");
    property p_no_oe_strobe; !program_strobe_n |-> !dev_sda_oe; endproperty
    a_no_oe_strobe: assert property (p_no_oe_strobe)
        else $error("device drives while strobe is low");
    property p_sclk_still; !program_strobe_n |-> sclk ##1 (sclk || program_strobe_n); endproperty
    a_sclk_still: assert property (p_sclk_still)
        else $error("sclk runs during strobe");
    property p_entry; !sclk || !program_strobe_n |-> vpp_on; endproperty
    a_entry: assert property (p_entry)
        else $error("link active without programming voltage");
    property p_byte_gap; $rose(sclk) ##1 !$rose(sclk)[*8]; endproperty
    c_byte_gap: cover property (p_byte_gap);
endmodule

// ===== bench/prom_serial_programming_port_tb.sv
/*
  Testbench: programmer end facing device end over one link.
  Assumes a shortened program pulse; the link clock comes from the programmer.
*/
`timescale 1ns/1ps
module prom_serial_programming_port_tb;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid = 1'b0;
    logic [1:0] req_op = 2'h0;
    logic [15:0] req_addr = 16'h0000;
    logic [15:0] req_data = 16'h0000;
    logic req_ready, rsp_valid, prog_mode, write_pulse;
    logic [15:0] rsp_data;
    logic [7:0] sent_sh = 8'h00;
    logic [7:0] last_sent = 8'h00;
    logic [15:0] got_sh = 16'h0000;
    int miscompares = 0;
    int n_compared = 0;
    int n_wr = 0;
    pspp_if link ();
    pspp_device pspp_device_i (.clk(clk), .reset_n(reset_n), .link(link),
        .prog_mode(prog_mode), .write_pulse(write_pulse));
    pspp_programmer #(.PROG_PULSE_CYC(30)) pspp_programmer_i (.clk(clk), .reset_n(reset_n),
        .link(link), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data));
    pspp_monitor pspp_monitor_i (.clk(clk), .reset_n(reset_n), .sclk(link.sclk),
        .program_strobe_n(link.program_strobe_n), .vpp_on(link.vpp_on),
        .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe),
        .prg_sda_out(link.prg_sda_out), .prg_sda_oe(link.prg_sda_oe), .sda(link.sda));

    always #10 clk = ~clk;
    // wire capture, bits arrive least significant first
    always @(posedge link.sclk) begin
        if (link.dev_sda_oe === 1'b1) got_sh = {link.sda, got_sh[15:1]};
        else sent_sh = {link.sda, sent_sh[7:1]};
    end
    always @(negedge link.program_strobe_n) last_sent = sent_sh;
    always @(negedge clk) if (write_pulse === 1'b1) n_wr++;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // one request, waits bounded, checks answer, wire bytes and writes
    task automatic do_op(input logic [1:0] op, input logic [15:0] a, input logic [15:0] d,
                         input logic [15:0] exp, input int wr);
        int i;
        int w0;
        w0 = n_wr;
        for (i = 0; i < 40000 && req_ready !== 1'b1; i++) @(negedge clk);
        if (req_ready !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_addr <= a;
        req_data <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        for (i = 0; i < 40000 && rsp_valid !== 1'b1; i++) @(negedge clk);
        if (rsp_valid !== 1'b1) begin
            miscompares++;
            tally_and_finish();
        end
        chk(rsp_data, exp);
        chk({8'h00, last_sent}, {8'h00, (op == pspp_pkg::OP_READ) ? a[15:8] : d[15:8]});
        if (op != pspp_pkg::OP_PROG) chk(got_sh, exp);
        chk(16'(n_wr - w0), 16'(wr));
    endtask

    initial begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        do_op(pspp_pkg::OP_PROG, 16'h0012, 16'hA5C3, 16'h0000, 1);
        chk({15'h0000, prog_mode}, 16'h0001);
        do_op(pspp_pkg::OP_READ, 16'h0012, 16'h0000, 16'hA5C3, 0);
        do_op(pspp_pkg::OP_VERIFY, 16'h07FF, 16'h5A3C, 16'h5A3C, 1);
        do_op(pspp_pkg::OP_READ, 16'h07FF, 16'h0000, 16'h5A3C, 0);
        do_op(pspp_pkg::OP_PROG, 16'h0000, 16'hFFFF, 16'h0000, 1);
        do_op(pspp_pkg::OP_READ, 16'h0000, 16'h0000, 16'hFFFF, 0);
        do_op(pspp_pkg::OP_READ, 16'h0012, 16'h0000, 16'hA5C3, 0);
        tally_and_finish();
    end
endmodule
